// *** common/rhpw_pkg.sv ***
// Package: offsets, field positions, reset values for root hub power/wakeup
`default_nettype none
package rhpw_pkg;
  // Register offsets inside the memory window
  localparam logic [7:0] RHPW_OFS_MASK_REMOVABLE = 8'h4c;
  localparam logic [7:0] RHPW_OFS_GLOBAL_STATUS = 8'h50;
  // Mask/removable register field positions
  localparam int RHPW_MASK_LSB = 16;
  localparam int RHPW_REMOVABLE_LSB = 0;
  localparam int RHPW_FIELD_W = 16;
  // Global status register bit positions
  localparam int RHPW_BIT_WAKE_CLR = 31;
  localparam int RHPW_BIT_OC_CHANGE = 17;
  localparam int RHPW_BIT_PWR_ON = 16;
  localparam int RHPW_BIT_WAKE_SET = 15;
  localparam int RHPW_BIT_OC_FLAG = 1;
  localparam int RHPW_BIT_PWR_OFF = 0;
  // Reset values
  localparam logic [15:0] RHPW_MASK_RESET = 16'h0000;
  localparam logic [15:0] RHPW_REMOVABLE_RESET = 16'h0000;
  // Power-state reset: all ports off
  localparam logic RHPW_PWR_RESET = 1'b0;
  // Suspend/resume tracking states
  typedef enum logic [1:0]
  {
    RHPW_ST_RUN = 2'b00,
    RHPW_ST_SUSPENDED = 2'b01,
    RHPW_ST_RESUMING = 2'b10
  } rhpw_state_type;
endpackage
`default_nettype wire

// *** rtl/rhpw_edge_flag.sv ***
// Sticky change flag: set on any edge of a level, cleared by write-one
`default_nettype none
module rhpw_edge_flag
  import rhpw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  input wire logic clear,
  output logic flag
);
  logic level_q; // Previous level for edge detection
  wire edge_seen = level ^ level_q;
  // Set dominates clear so a coincident edge is not lost
  wire next_flag = edge_seen | (flag & ~clear);

  // Edge history and sticky flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level_q <= 1'b0;
      flag <= 1'b0;
    end
    else
    begin
      level_q <= level;
      flag <= next_flag;
    end
  end

  edge_sets_a: assert property (@(posedge clk) disable iff (rst)
    (level != $past(level)) |=> flag)
    else $error("change flag missed an edge");
endmodule
`default_nettype wire

// *** rtl/rhpw_port_power.sv ***
// One port's power state, steered by global and per-port commands
`default_nettype none
module rhpw_port_power
  import rhpw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic per_port_mode,
  input wire logic mask_bit,
  input wire logic global_on,
  input wire logic global_off,
  input wire logic port_on,
  input wire logic port_off,
  input wire logic overcurrent,
  output logic port_power_state
);
  // Mask only matters in per-port mode; otherwise global owns the port
  wire use_port = per_port_mode & mask_bit;
  wire set_cmd = use_port ? port_on : global_on;
  wire clr_cmd = use_port ? port_off : global_off;
  // Overcurrent and clear win over set, keeping the switch safe
  wire next_power = (port_power_state | set_cmd) & ~clr_cmd & ~overcurrent;

  // Power state register
  always_ff @(posedge clk)
  begin
    if (rst)
      port_power_state <= RHPW_PWR_RESET;
    else
      port_power_state <= next_power;
  end

  masked_hold_a: assert property (@(posedge clk) disable iff (rst)
    (use_port & ~port_on & ~port_off)
      |=> (port_power_state <= $past(port_power_state)))
    else $error("masked port moved on a global command");
endmodule
`default_nettype wire

// *** rtl/rhpw_regs.sv ***
// Root hub port mask/removable and global status register bank
// Contract
// - Mask bit set: per-port commands only
// - Mask bit clear: global commands only
// - Mask ignored in global switching mode
// - Mask bit 0 reserved, bits 1..2 ports
// - Removable flags, set means not removable
// - Removable bit 0 reserved, bits 1..2 ports
// - Status low half, change bits high
// - Write one bit 31 clears wakeup enable
// - Overcurrent change set on change, W1C
// - Bit 16 always reads zero
// - Global mode: bit 16 powers all on
// - Per-port mode: bit 16 powers unmasked ports
// - Wakeup enabled: connect change resumes from suspend
// - Write one bit 15 sets wakeup enable
// - Bit 1 shows global overcurrent only
// - Bit 0 always reads zero
// - Global mode: bit 0 powers all off
// - Per-port mode: bit 0 clears unmasked ports
// - Global mode: only global commands drive power
`default_nettype none
module rhpw_regs
  import rhpw_pkg::*;
#(
  parameter int NUM_PORTS = 2
)
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input wire logic PER_PORT_MODE,
  input wire logic PER_PORT_OC,
  input wire logic OVERCURRENT_IN,
  input wire logic [NUM_PORTS:1] PORT_ON_CMD,
  input wire logic [NUM_PORTS:1] PORT_OFF_CMD,
  input wire logic [NUM_PORTS:1] PORT_OC,
  input wire logic [NUM_PORTS:1] CONNECT_CHANGE_FLAG,
  input wire logic SUSPEND_REQ,
  input wire logic RESUME_DONE,
  output logic [NUM_PORTS:1] PORT_POWER_STATE,
  output logic [15:0] PORT_POWER_MASK,
  output logic [15:0] DEVICE_REMOVABLE_FLAGS,
  output logic REMOTE_WAKEUP_ENABLE,
  output logic RESUME_DETECTED,
  output logic [1:0] HUB_STATE
);
  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire sel_mask = REG_ADDR == RHPW_OFS_MASK_REMOVABLE;
  wire sel_stat = REG_ADDR == RHPW_OFS_GLOBAL_STATUS;
  wire wr_mask = REG_WR & sel_mask; // Load of mask/removable
  wire wr_stat = REG_WR & sel_stat;
  // Write-one command strobes from the status register
  wire wakeup_enable_clear = wr_stat & REG_WDATA[RHPW_BIT_WAKE_CLR];
  wire wakeup_enable_set = wr_stat & REG_WDATA[RHPW_BIT_WAKE_SET];
  wire global_power_on_cmd = wr_stat & REG_WDATA[RHPW_BIT_PWR_ON];
  wire global_power_off_cmd = wr_stat & REG_WDATA[RHPW_BIT_PWR_OFF];
  wire oc_change_clear = wr_stat & REG_WDATA[RHPW_BIT_OC_CHANGE];

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent indicator: meaningful only with global reporting
  wire global_overcurrent_flag = OVERCURRENT_IN & ~PER_PORT_OC;
  logic overcurrent_change_flag; // Sticky change of the indicator

  rhpw_edge_flag u_oc_change
  (
    .clk(MCLK),
    .rst(SYS_RST),
    .level(global_overcurrent_flag),
    .clear(oc_change_clear),
    .flag(overcurrent_change_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mask and removable storage; reserved bit 0 kept as stored
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      PORT_POWER_MASK <= RHPW_MASK_RESET;
      DEVICE_REMOVABLE_FLAGS <= RHPW_REMOVABLE_RESET;
    end
    else if (wr_mask)
    begin
      PORT_POWER_MASK <= REG_WDATA[RHPW_MASK_LSB +: RHPW_FIELD_W];
      DEVICE_REMOVABLE_FLAGS <=
        REG_WDATA[RHPW_REMOVABLE_LSB +: RHPW_FIELD_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port power: mask bit p maps to port p, bit 0 is never used
  genvar p;
  generate
    for (p = 1; p <= NUM_PORTS; p++)
    begin : g_port
      rhpw_port_power u_pwr
      (
        .clk(MCLK),
        .rst(SYS_RST),
        .per_port_mode(PER_PORT_MODE),
        .mask_bit(PORT_POWER_MASK[p]),
        .global_on(global_power_on_cmd),
        .global_off(global_power_off_cmd),
        .port_on(PORT_ON_CMD[p]),
        .port_off(PORT_OFF_CMD[p]),
        .overcurrent(PORT_OC[p]),
        .port_power_state(PORT_POWER_STATE[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Remote wakeup enable; a set and clear together leave it set
  wire next_wakeup = wakeup_enable_set |
    (REMOTE_WAKEUP_ENABLE & ~wakeup_enable_clear);

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      REMOTE_WAKEUP_ENABLE <= 1'b0;
    else
      REMOTE_WAKEUP_ENABLE <= next_wakeup;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Suspend/resume tracking; connect change wakes only when enabled
  rhpw_state_type state;
  rhpw_state_type next_state;
  wire wake_event = REMOTE_WAKEUP_ENABLE & (|CONNECT_CHANGE_FLAG);
  logic resume_pulse;

  always_comb
  begin
    next_state = state;
    resume_pulse = 1'b0;
    case (state)
      RHPW_ST_RUN:
        if (SUSPEND_REQ)
          next_state = RHPW_ST_SUSPENDED;
      RHPW_ST_SUSPENDED:
        if (wake_event)
        begin
          next_state = RHPW_ST_RESUMING;
          resume_pulse = 1'b1;
        end
      RHPW_ST_RESUMING:
        if (RESUME_DONE)
          next_state = RHPW_ST_RUN;
      default:
        next_state = RHPW_ST_RUN;
    endcase
  end

  // State and resume-detected pulse
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      state <= RHPW_ST_RUN;
      RESUME_DETECTED <= 1'b0;
    end
    else
    begin
      state <= next_state;
      RESUME_DETECTED <= resume_pulse;
    end
  end

  assign HUB_STATE = state;

  ////////////////////////////////////////////////////////////////////////////
  // Read data; power command bits 16 and 0 read zero
  logic [31:0] stat_word;
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[RHPW_BIT_OC_CHANGE] = overcurrent_change_flag;
    stat_word[RHPW_BIT_PWR_ON] = 1'b0;
    stat_word[RHPW_BIT_WAKE_SET] = REMOTE_WAKEUP_ENABLE;
    stat_word[RHPW_BIT_OC_FLAG] = global_overcurrent_flag;
    stat_word[RHPW_BIT_PWR_OFF] = 1'b0;
  end

  wire [31:0] mask_word = {PORT_POWER_MASK, DEVICE_REMOVABLE_FLAGS};
  wire [31:0] rd_mux = sel_mask ? mask_word :
    (sel_stat ? stat_word : 32'h0000_0000);

  // Registered read data, unmapped addresses return zero
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      REG_RDATA <= 32'h0000_0000;
    else if (REG_RD)
      REG_RDATA <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wake_clear_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (wakeup_enable_clear & ~wakeup_enable_set)
      |=> !REMOTE_WAKEUP_ENABLE)
    else $error("wakeup enable not cleared");
  wake_set_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    wakeup_enable_set |=> REMOTE_WAKEUP_ENABLE)
    else $error("wakeup enable not set");
  wake_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (wr_stat & ~REG_WDATA[31] & ~REG_WDATA[15])
      |=> $stable(REMOTE_WAKEUP_ENABLE))
    else $error("zero write moved wakeup enable");
  oc_clear_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (oc_change_clear & $stable(global_overcurrent_flag))
      |=> !overcurrent_change_flag)
    else $error("overcurrent change not cleared");
  status_zero_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (REG_RD & sel_stat) |=> (REG_RDATA[16] == 1'b0 && REG_RDATA[0] == 1'b0))
    else $error("local power bits read nonzero");
  oc_read_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (REG_RD & sel_stat & PER_PORT_OC) |=> REG_RDATA[1] == 1'b0)
    else $error("indicator read set in per-port mode");
  global_on_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (global_power_on_cmd & ~global_power_off_cmd & ~PER_PORT_MODE & ~(|PORT_OC))
      |=> &PORT_POWER_STATE)
    else $error("global on missed a port");
  global_off_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (global_power_off_cmd & ~PER_PORT_MODE) |=> ~(|PORT_POWER_STATE))
    else $error("global off missed a port");
  resume_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state == RHPW_ST_SUSPENDED && wake_event)
      |=> (RESUME_DETECTED && state == RHPW_ST_RESUMING))
    else $error("resume not taken on wake event");
endmodule
`default_nettype wire

// *** testbench/test_root_hub_power_wakeup_regs.sv ***
// Self-checking bench for the root hub power and wakeup register bank
`default_nettype none
module test_root_hub_power_wakeup_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import rhpw_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed ports
  logic MCLK = 1'h0;
  logic SYS_RST = 1'h1;
  logic REG_WR = 1'h0, REG_RD = 1'h0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
  logic PER_PORT_MODE = 1'h0, PER_PORT_OC = 1'h0, OVERCURRENT_IN = 1'h0;
  logic [2:1] PORT_ON_CMD = 2'h0, PORT_OFF_CMD = 2'h0, PORT_OC = 2'h0;
  logic [2:1] CONNECT_CHANGE_FLAG = 2'h0, PORT_POWER_STATE;
  logic SUSPEND_REQ = 1'h0, RESUME_DONE = 1'h0;
  logic REMOTE_WAKEUP_ENABLE, RESUME_DETECTED;
  logic [15:0] PORT_POWER_MASK, DEVICE_REMOVABLE_FLAGS;
  logic [1:0] HUB_STATE;
  // One expected read result, noted when the read is issued
  typedef struct {logic [31:0] d; logic [2:1] p; logic [1:0] h; int r;
    logic [31:0] m; logic w;} rhpw_note_type;
  rhpw_note_type notes[$];
  rhpw_note_type n;
  rhpw_note_type m; // Monitor's own copy, kept apart from the issuing side
  int fail_count = 0, samples_checked = 0, res_cnt = 0, e_res = 0;
  // Reference model of the register state
  logic [31:0] e_mr = 32'h0;
  logic [2:1] e_pwr = 2'h0;
  logic [1:0] e_hub = 2'h0;
  logic e_wake = 1'h0, e_chg = 1'h0, e_oc = 1'h0, rd_seen = 1'h0;
  ////////////////////////////////////////////////////////////////////////////
  initial forever #20 MCLK = ~MCLK;
  rhpw_regs #(.NUM_PORTS(2)) u_rhpw_regs (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .PER_PORT_MODE(PER_PORT_MODE), .PER_PORT_OC(PER_PORT_OC),
    .OVERCURRENT_IN(OVERCURRENT_IN), .PORT_ON_CMD(PORT_ON_CMD),
    .PORT_OFF_CMD(PORT_OFF_CMD), .PORT_OC(PORT_OC),
    .CONNECT_CHANGE_FLAG(CONNECT_CHANGE_FLAG), .SUSPEND_REQ(SUSPEND_REQ),
    .RESUME_DONE(RESUME_DONE), .PORT_POWER_STATE(PORT_POWER_STATE),
    .PORT_POWER_MASK(PORT_POWER_MASK),
    .DEVICE_REMOVABLE_FLAGS(DEVICE_REMOVABLE_FLAGS),
    .REMOTE_WAKEUP_ENABLE(REMOTE_WAKEUP_ENABLE),
    .RESUME_DETECTED(RESUME_DETECTED), .HUB_STATE(HUB_STATE));
  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per kind of result
  task automatic cmp32(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmp2(input logic [1:0] got, exp, input string m);
    cmp32({30'h0, got}, {30'h0, exp}, m);
  endtask
  task automatic cmpn(input int got, exp);
    cmp32(got, exp, "resume count");
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle; bus and event inputs are reassigned so pulses last one cycle
  task automatic cyc(input logic w, r, input logic [7:0] a,
                     input logic [31:0] d, input logic [5:0] ev);
    @(posedge MCLK);
    REG_WR <= w;
    REG_RD <= r;
    REG_ADDR <= a;
    REG_WDATA <= d;
    {RESUME_DONE, SUSPEND_REQ, CONNECT_CHANGE_FLAG, PORT_ON_CMD} <= ev;
  endtask
  task automatic idle(input int k);
    repeat (k) cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h00);
  endtask
  // Register write plus its effect on the model; power clear beats set, wakeup set beats clear
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1'h1, 1'h0, a, d, 6'h00);
    if (a == RHPW_OFS_MASK_REMOVABLE)
      e_mr = d;
    if (a == RHPW_OFS_GLOBAL_STATUS)
    begin
      for (int i = 1; i <= 2; i++)
        if (!PER_PORT_MODE || !e_mr[16+i])
          e_pwr[i] = d[0] ? 1'h0 : (d[16] ? 1'h1 : e_pwr[i]);
      e_wake = d[15] | (e_wake & ~d[31]);
      if (d[17])
        e_chg = 1'h0;
    end
  endtask
  // Per-port power-on pulse; only masked ports in per-port mode obey
  task automatic pon(input logic [2:1] b);
    cyc(1'h0, 1'h0, 8'h00, 32'h0, {4'h0, b});
    for (int i = 1; i <= 2; i++)
      if (PER_PORT_MODE && e_mr[16+i] && b[i])
        e_pwr[i] = 1'h1;
  endtask
  // Per-port power-off pulse for one cycle; masked ports obey in per-port mode
  task automatic poff(input logic [2:1] b);
    cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h00);
    PORT_OFF_CMD <= b;
    for (int i = 1; i <= 2; i++)
      if (PER_PORT_MODE && e_mr[16+i] && b[i])
        e_pwr[i] = 1'h0;
    cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h00);
    PORT_OFF_CMD <= 2'h0;
  endtask
  // Read: the expected word is noted now and checked by the monitor
  task automatic rd(input logic [7:0] a);
    n.d = (a == RHPW_OFS_MASK_REMOVABLE) ? e_mr :
          (a == RHPW_OFS_GLOBAL_STATUS) ?
          {14'h0, e_chg, 1'h0, e_wake, 13'h0, e_oc, 1'h0} : 32'h0;
    n.p = e_pwr;
    n.h = e_hub;
    n.r = e_res;
    n.m = e_mr;
    n.w = e_wake;
    notes.push_back(n);
    cyc(1'h0, 1'h1, a, 32'h0, 6'h00);
  endtask
  // Level inputs; the change flag follows the gated indicator
  task automatic lv(input logic oc, per, m);
    @(posedge MCLK);
    OVERCURRENT_IN <= oc;
    PER_PORT_OC <= per;
    PER_PORT_MODE <= m;
    if ((oc & ~per) != e_oc)
      e_chg = 1'h1;
    e_oc = oc & ~per;
    idle(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: read data lands one cycle after the read is taken
  always @(posedge MCLK)
  begin
    if (rd_seen && notes.size() > 0)
    begin
      m = notes.pop_front();
      cmp32(REG_RDATA, m.d, "read data");
      cmp2(PORT_POWER_STATE, m.p, "power");
      cmp2(HUB_STATE, m.h, "hub state");
      cmpn(res_cnt, m.r);
      cmp32({PORT_POWER_MASK, DEVICE_REMOVABLE_FLAGS}, m.m, "fields");
      cmp2({1'h0, REMOTE_WAKEUP_ENABLE}, {1'h0, m.w}, "wakeup");
    end
    if (RESUME_DETECTED === 1'h1)
      res_cnt++;
    rd_seen <= REG_RD;
  end
  // Watchdog: the run needs well under a thousand cycles
  initial
  begin
    #200000;
    fail_count++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h19cc21a1));
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'h0;
    // Reset values, unmapped write ignored and unmapped read zero
    rd(RHPW_OFS_MASK_REMOVABLE);
    rd(RHPW_OFS_GLOBAL_STATUS);
    wr(RHPW_OFS_MASK_REMOVABLE, $urandom() & 32'hf7ff_ffff);
    wr(8'h54, 32'hffff_ffff);
    rd(RHPW_OFS_MASK_REMOVABLE);
    rd(8'h54);
    // Overcurrent indicator, its change flag and per-port gating
    lv(1'h1, 1'h0, 1'h0);
    rd(RHPW_OFS_GLOBAL_STATUS);
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h0002_0000);
    rd(RHPW_OFS_GLOBAL_STATUS);
    lv(1'h1, 1'h1, 1'h0);
    rd(RHPW_OFS_GLOBAL_STATUS);
    lv(1'h0, 1'h0, 1'h0);
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h0002_0000);
    // Global mode ignores mask and per-port pulses
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h0001_0000);
    pon(2'h3);
    rd(RHPW_OFS_GLOBAL_STATUS);
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h0000_0001);
    rd(RHPW_OFS_GLOBAL_STATUS);
    // Per-port mode with port 1 masked
    lv(1'h0, 1'h0, 1'h1);
    wr(RHPW_OFS_MASK_REMOVABLE, 32'h0002_0000);
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h0001_0000);
    rd(RHPW_OFS_GLOBAL_STATUS);
    pon(2'h3);
    rd(RHPW_OFS_GLOBAL_STATUS);
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h0000_0001);
    rd(RHPW_OFS_GLOBAL_STATUS);
    // Wakeup enabled: connect change resumes from suspend
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h0000_8000);
    cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h10);
    e_hub = 2'h1;
    cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h04);
    e_hub = 2'h2;
    e_res++;
    idle(3);
    rd(RHPW_OFS_GLOBAL_STATUS);
    cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h20);
    e_hub = 2'h0;
    // Wakeup cleared: connect change leaves the hub suspended
    wr(RHPW_OFS_GLOBAL_STATUS, 32'h8000_0000);
    cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h10);
    e_hub = 2'h1;
    cyc(1'h0, 1'h0, 8'h00, 32'h0, 6'h08);
    idle(3);
    rd(RHPW_OFS_GLOBAL_STATUS);
    // Random modes, masks and command words with reserved bits zero
    repeat (24)
    begin
      lv(1'h0, 1'h0, 1'($urandom_range(1)));
      wr(RHPW_OFS_MASK_REMOVABLE, $urandom() & 32'hf7ff_ffff);
      wr(RHPW_OFS_GLOBAL_STATUS, $urandom() & 32'h8003_8001);
      pon(2'($urandom_range(3)));
      poff(2'($urandom_range(3)));
      rd(RHPW_OFS_GLOBAL_STATUS);
    end
    idle(3);
    end_of_test();
  end
endmodule
`default_nettype wire
